/* File: slot_remap_defs.vh */
// Constants for the slot remapping table
`ifndef SLOT_REMAP_DEFS_VH
`define SLOT_REMAP_DEFS_VH
`define REMAP_RECORD_INDEX  8'h7F
`define REMAP_RECORD_BYTES  7'h40
`define REMAP_SLOTS         7'h40
`define REMAP_CODE_IGNORE   8'h00
`define REMAP_CODE_SLOT_MIN 8'h01
`define REMAP_CODE_SLOT_MAX 8'h40
`define REMAP_CODE_VIRTUAL  8'hFF
`define REMAP_RESET_BYTE    8'h00
`endif

/* File: slot_remap_decode.v */
// Decoder of one mapping byte into slot routing flags
`timescale 1ns/1ns
module slot_remap_decode
(
  input  wire [7:0] i_code,      // Mapping byte
  output wire       o_routed,    // Byte names a fitted slot
  output wire       o_virtual,   // Virtual module
  output wire       o_ignored,   // Slot left as a gap
  output wire       o_bad,       // Reserved code value
  output wire [5:0] o_slot       // Zero based actual slot
);
`include "slot_remap_defs.vh"
  wire [7:0] code_m1;            // Code minus one

  assign code_m1   = i_code - 8'h01;
  assign o_ignored = (i_code == `REMAP_CODE_IGNORE);
  assign o_virtual = (i_code == `REMAP_CODE_VIRTUAL);
  assign o_routed  = (i_code >= `REMAP_CODE_SLOT_MIN) && (i_code <= `REMAP_CODE_SLOT_MAX);
  // Values 65..254 hold no meaning and poison the record
  assign o_bad     = !o_ignored && !o_virtual && !o_routed;
  assign o_slot    = code_m1[5:0];
endmodule

/* File: slot_remap_table.v */
// Slot remapping table between planned and fitted I/O slots
`timescale 1ns/1ns
module slot_remap_table
#(
  parameter SLOT_W = 6             // Slot number width
)
(
  input  wire        I_CLK_SYS,        // System clock, 10 MHz
  input  wire        I_RST_N,          // Synchronous reset, active low
  input  wire        I_CE,             // Clock enable, freezes state
  input  wire        I_REMAP_ENABLE,   // slot_remap_function parameter
  input  wire        I_WR_START,       // Record write command start
  input  wire [7:0]  I_WR_INDEX,       // Record index of write
  input  wire        I_WR_VALID,       // Write data byte strobe
  input  wire [7:0]  I_WR_DATA,        // Write data byte
  input  wire        I_WR_END,         // Record write command end
  input  wire        I_RD_REQ,         // Record read byte request
  input  wire [7:0]  I_RD_INDEX,       // Record index of read
  input  wire [5:0]  I_RD_ADDR,        // Byte offset within record
  input  wire [5:0]  I_TGT_SLOT,       // Target slot of image access
  input  wire        I_TGT_WR,         // Output image write
  input  wire [7:0]  I_TGT_WDATA,      // Output image byte
  input  wire [63:0] I_SLOT_PRESENT,   // Fitted module flags, per slot
  input  wire [7:0]  I_ACT_RDATA,      // Input byte from actual slot
  input  wire [511:0] I_NV_DATA,       // Retentive store contents
  input  wire        I_NV_READY,       // Retentive store loaded
  output reg         O_WR_DONE,        // Record accepted
  output reg         O_WR_ERROR,       // Record refused
  output reg  [7:0]  O_RD_DATA,        // Record read byte
  output reg         O_RD_VALID,       // Read byte valid
  output reg         O_RD_ERROR,       // Read index wrong
  output wire [5:0]  O_ACT_SLOT,       // Actual slot addressed
  output wire        O_ACT_WR,         // Write forwarded to slot
  output wire [7:0]  O_ACT_WDATA,      // Data forwarded to slot
  output wire        O_ACT_RD,         // Read routed to slot
  output wire [7:0]  O_TGT_RDATA,      // Input byte to image
  output reg         O_NV_STORE,       // Store pulse to retentive memory
  output reg  [511:0] O_NV_DATA,       // Record to store
  output reg         O_CFG_MISMATCH    // Startup planned/fitted mismatch
);
`include "slot_remap_defs.vh"

  // Commit sequence states
  localparam ST_IDLE   = 2'h0;     // Waiting for a write command
  localparam ST_LOAD   = 2'h1;     // Collecting record bytes
  localparam ST_CHECK  = 2'h2;     // Length and index verdict
  localparam ST_COMMIT = 2'h3;     // Answer and apply

  ////////////////////////////////////////////////////////////////////
  // Storage
  reg  [7:0]   map_active [0:63];  // Active mapping bytes
  reg  [7:0]   map_shadow [0:63];  // Incoming record bytes
  reg  [6:0]   wr_count;           // Bytes received
  reg          wr_open;            // Write command to the record index
  reg          wr_bad;             // Record refused: reserved code, wrong length or index
  reg          wr_differs;         // Record differs from active
  reg          loaded;             // Retentive image loaded once
  reg  [1:0]   state;              // Commit sequence state
  reg  [1:0]   next_state;         // Next commit state
  reg  [1:0]   en_sync;            // Enable strap synchroniser
  reg  [1:0]   nv_sync;            // Store ready synchroniser
  reg  [127:0] pres_sync;          // Presence synchroniser, two stages
  wire         remap_on;           // Synchronised enable
  wire [63:0]  present;            // Synchronised presence
  wire         dec_routed;         // Access decode: fitted slot named
  wire [5:0]   dec_slot;           // Access decode: actual slot
  wire         in_bad;             // Incoming byte reserved
  wire [7:0]   tgt_code;           // Code for the addressed target
  integer      k;

  assign remap_on = en_sync[1];
  assign present  = pres_sync[127:64];

  ////////////////////////////////////////////////////////////////////
  // Input synchronisers for pin level signals
  always @(posedge I_CLK_SYS)
  begin
    if (!I_RST_N)
    begin
      en_sync   <= 2'h0;
      nv_sync   <= 2'h0;
      pres_sync <= 128'h0;
    end
    else if (I_CE)
    begin
      en_sync   <= {en_sync[0], I_REMAP_ENABLE};
      nv_sync   <= {nv_sync[0], I_NV_READY};
      pres_sync <= {pres_sync[63:0], I_SLOT_PRESENT};
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Decode of the image access and of incoming bytes
  assign tgt_code = map_active[I_TGT_SLOT];

  slot_remap_decode u_dec_acc
  (
    .i_code    (tgt_code),
    .o_routed  (dec_routed),
    .o_virtual (),
    .o_ignored (),
    .o_bad     (),
    .o_slot    (dec_slot)
  );

  slot_remap_decode u_dec_in
  (
    .i_code    (I_WR_DATA),
    .o_routed  (),
    .o_virtual (),
    .o_ignored (),
    .o_bad     (in_bad),
    .o_slot    ()
  );

  ////////////////////////////////////////////////////////////////////
  // Image routing; straight through while remapping is off
  // bypass when disabled
  assign O_ACT_SLOT  = remap_on ? dec_slot : I_TGT_SLOT;
  assign O_ACT_WR    = I_TGT_WR && (!remap_on || (dec_routed && present[dec_slot]));
  assign O_ACT_WDATA = I_TGT_WDATA;
  assign O_ACT_RD    = !remap_on || (dec_routed && present[dec_slot]);
  assign O_TGT_RDATA = O_ACT_RD ? I_ACT_RDATA : 8'h00;

  ////////////////////////////////////////////////////////////////////
  // Write record collection and commit sequence
  always @*
  begin
    next_state = state;
    case (state)
      ST_IDLE:   next_state = I_WR_START ? ST_LOAD : ST_IDLE;
      ST_LOAD:   next_state = I_WR_END ? ST_CHECK : ST_LOAD;
      ST_CHECK:  next_state = ST_COMMIT;
      ST_COMMIT: next_state = ST_IDLE;
      default:   next_state = ST_IDLE;
    endcase
  end

  always @(posedge I_CLK_SYS)
  begin
    if (!I_RST_N)
    begin
      state      <= ST_IDLE;
      wr_count   <= 7'h00;
      wr_open    <= 1'b0;
      wr_bad     <= 1'b0;
      wr_differs <= 1'b0;
      loaded     <= 1'b0;
      O_WR_DONE  <= 1'b0;
      O_WR_ERROR <= 1'b0;
      O_NV_STORE <= 1'b0;
      O_NV_DATA  <= 512'h0;
      for (k = 0; k < 64; k = k + 1)
      begin
        map_active[k] <= `REMAP_RESET_BYTE;
        map_shadow[k] <= `REMAP_RESET_BYTE;
      end
    end
    else if (I_CE)
    begin
      state      <= next_state;
      O_WR_DONE  <= 1'b0;
      O_WR_ERROR <= 1'b0;
      O_NV_STORE <= 1'b0;
      if (!loaded && nv_sync[1])
      begin
        loaded <= 1'b1;
        for (k = 0; k < 64; k = k + 1)
          map_active[k] <= I_NV_DATA[8*k +: 8];
      end
      case (state)
        ST_IDLE:
        begin
          wr_open    <= I_WR_START && (I_WR_INDEX == `REMAP_RECORD_INDEX);
          wr_count   <= 7'h00;
          wr_bad     <= 1'b0;
          wr_differs <= 1'b0;
        end
        ST_LOAD:
        begin
          if (I_WR_VALID && wr_count < `REMAP_RECORD_BYTES)
          begin
            map_shadow[wr_count[5:0]] <= I_WR_DATA;
            wr_count <= wr_count + 7'h01;
            if (in_bad)
              wr_bad <= 1'b1;
            if (I_WR_DATA != map_active[wr_count[5:0]])
              wr_differs <= 1'b1;
          end
          else if (I_WR_VALID)
            wr_bad <= 1'b1;  // Overlong record
        end
        ST_CHECK:
        begin
          if (wr_count != `REMAP_RECORD_BYTES)
            wr_bad <= 1'b1;
          if (!wr_open)
            wr_bad <= 1'b1;
        end
        ST_COMMIT:
        begin
          if (wr_bad)
            O_WR_ERROR <= 1'b1;
          else
          begin
            O_WR_DONE <= 1'b1;
            for (k = 0; k < 64; k = k + 1)
              map_active[k] <= map_shadow[k];
            if (wr_differs)
            begin
              O_NV_STORE <= 1'b1;
              for (k = 0; k < 64; k = k + 1)
                O_NV_DATA[8*k +: 8] <= map_shadow[k];
            end
          end
        end
        default:
          wr_open <= 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Record read path, one byte per request
  always @(posedge I_CLK_SYS)
  begin
    if (!I_RST_N)
    begin
      O_RD_DATA  <= 8'h00;
      O_RD_VALID <= 1'b0;
      O_RD_ERROR <= 1'b0;
    end
    else if (I_CE)
    begin
      O_RD_VALID <= I_RD_REQ && (I_RD_INDEX == `REMAP_RECORD_INDEX);
      O_RD_ERROR <= I_RD_REQ && (I_RD_INDEX != `REMAP_RECORD_INDEX);
      O_RD_DATA  <= I_RD_REQ ? map_active[I_RD_ADDR] : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Startup mismatch: a routed byte pointing at an empty slot, or any empty slot while remapping is off
  always @(posedge I_CLK_SYS)
  begin
    if (!I_RST_N)
      O_CFG_MISMATCH <= 1'b0;
    else if (I_CE)
    begin
      O_CFG_MISMATCH <= 1'b0;
      if (remap_on)
      begin
        for (k = 0; k < 64; k = k + 1)
          if (map_active[k] >= `REMAP_CODE_SLOT_MIN && map_active[k] <= `REMAP_CODE_SLOT_MAX
              && !present[map_active[k][5:0] - 6'h01])
            O_CFG_MISMATCH <= 1'b1;
      end
      else if (present != 64'hFFFFFFFFFFFFFFFF)
        O_CFG_MISMATCH <= 1'b1;  // Plain check: all slots expected
    end
  end
endmodule

/* File: slot_remap_table_checker.sv */
// Port checker of the slot remapping table
`timescale 1ns/1ns
module slot_remap_table_checker
(
  input wire       I_CLK_SYS,
  input wire       I_RST_N,
  input wire       I_CE,
  input wire       I_REMAP_ENABLE,
  input wire       I_WR_END,
  input wire       I_RD_REQ,
  input wire [7:0] I_RD_INDEX,
  input wire [5:0] I_TGT_SLOT,
  input wire       I_TGT_WR,
  input wire [7:0] I_TGT_WDATA,
  input wire [7:0] I_ACT_RDATA,
  input wire       O_WR_DONE,
  input wire       O_WR_ERROR,
  input wire       O_RD_VALID,
  input wire       O_RD_ERROR,
  input wire [5:0] O_ACT_SLOT,
  input wire       O_ACT_WR,
  input wire [7:0] O_ACT_WDATA,
  input wire       O_ACT_RD,
  input wire [7:0] O_TGT_RDATA,
  input wire       O_NV_STORE
);
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RST_N);
  ////////////////////////////////////////////////////////////////////////////
  property p_one_answer; !(O_WR_DONE && O_WR_ERROR); endproperty
  a_one_answer: assert property (p_one_answer) else $error("two answers");
  property p_answer; I_WR_END |-> ##[2:3] (O_WR_DONE || O_WR_ERROR); endproperty
  a_answer: assert property (p_answer) else $error("no write answer");
  property p_store; O_NV_STORE |-> O_WR_DONE; endproperty
  a_store: assert property (p_store) else $error("store of refused record");
  property p_rd_ok; I_CE && I_RD_REQ && I_RD_INDEX == 8'h7F |=> O_RD_VALID && !O_RD_ERROR;
  endproperty
  a_rd_ok: assert property (p_rd_ok) else $error("read not answered");
  property p_rd_bad; I_CE && I_RD_REQ && I_RD_INDEX != 8'h7F |=> O_RD_ERROR && !O_RD_VALID;
  endproperty
  a_rd_bad: assert property (p_rd_bad) else $error("wrong index read");
  property p_wr_pass; O_ACT_WR |-> I_TGT_WR && O_ACT_WDATA == I_TGT_WDATA; endproperty
  a_wr_pass: assert property (p_wr_pass) else $error("bad slot write");
  property p_rd_zero; O_TGT_RDATA == (O_ACT_RD ? I_ACT_RDATA : 8'h00); endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("bad image byte");
  property p_off; !I_REMAP_ENABLE [*3] |-> O_ACT_SLOT == I_TGT_SLOT; endproperty
  a_off: assert property (p_off) else $error("remap while off");
  // A low clock enable holds every registered answer
  property p_freeze;
    !I_CE |=> $stable({O_WR_DONE, O_WR_ERROR, O_RD_VALID, O_RD_ERROR, O_NV_STORE});
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen"); // Clock enable
endmodule
bind slot_remap_table slot_remap_table_checker i_slot_remap_table_checker
(
  .I_CLK_SYS, .I_RST_N, .I_CE, .I_REMAP_ENABLE, .I_WR_END, .I_RD_REQ, .I_RD_INDEX, .I_TGT_SLOT,
  .I_TGT_WR, .I_TGT_WDATA, .I_ACT_RDATA, .O_WR_DONE, .O_WR_ERROR, .O_RD_VALID, .O_RD_ERROR,
  .O_ACT_SLOT, .O_ACT_WR, .O_ACT_WDATA, .O_ACT_RD, .O_TGT_RDATA, .O_NV_STORE
);

/* File: slot_io_modules.sv */
// Model of the I/O modules fitted in backplane slots
`timescale 1ns/1ns
module slot_io_modules
(
  input  wire       i_clk,   // System clock
  input  wire [5:0] i_slot,  // Slot addressed
  input  wire       i_rd,    // Read routed to slot
  output wire [7:0] o_rdata  // Input byte of slot
);
  reg [7:0] junk = 8'h00;    // Moves each cycle so a stale byte never matches
  always @(posedge i_clk)
  begin
    junk <= junk + 8'h3B;
  end
  // Each module answers with its slot number below top bits 10
  assign o_rdata = i_rd ? {2'b10, i_slot} : junk;
endmodule

/* File: slot_remap_table_tb.sv */
// Self-checking testbench of the slot remapping table
`timescale 1ns/1ns
module slot_remap_table_tb;
  reg          I_CLK_SYS = 0, I_RST_N = 0, I_REMAP_ENABLE = 0, I_NV_READY = 0, on = 0;
  reg          I_WR_START = 0, I_WR_VALID = 0, I_WR_END = 0, I_RD_REQ = 0, I_TGT_WR = 0;
  reg  [7:0]   I_WR_INDEX = 0, I_WR_DATA = 0, I_RD_INDEX = 0, I_TGT_WDATA = 0;
  reg  [5:0]   I_RD_ADDR = 0, I_TGT_SLOT = 0;
  reg          I_CE = 1;                               // Clock enable, dropped once
  reg  [63:0]  I_SLOT_PRESENT = 64'hFFFF_FFFF_FFFF_FFCF; // Slots 4 and 5 empty
  reg  [511:0] I_NV_DATA = 0, mdl = 0, rec = 0, qs[$]; // Expected, sent, stores
  reg  [8:0]   qr[$];                                  // Read notes
  reg  [1:0]   qw[$];                                  // Write answer notes
  wire         O_WR_DONE, O_WR_ERROR, O_RD_VALID, O_RD_ERROR, O_ACT_WR, O_ACT_RD;
  wire         O_NV_STORE, O_CFG_MISMATCH;
  wire [7:0]   I_ACT_RDATA, O_RD_DATA, O_ACT_WDATA, O_TGT_RDATA;
  wire [5:0]   O_ACT_SLOT;
  wire [511:0] O_NV_DATA;
  integer      fails = 0, compares = 0, seed = 32'he1e4, cyc = 0, i, j, k;
  slot_remap_table i_slot_remap_table
  (
    .I_CLK_SYS, .I_RST_N, .I_CE, .I_REMAP_ENABLE, .I_WR_START, .I_WR_INDEX,
    .I_WR_VALID, .I_WR_DATA, .I_WR_END, .I_RD_REQ, .I_RD_INDEX, .I_RD_ADDR, .I_TGT_SLOT,
    .I_TGT_WR, .I_TGT_WDATA, .I_SLOT_PRESENT, .I_ACT_RDATA, .I_NV_DATA, .I_NV_READY,
    .O_WR_DONE, .O_WR_ERROR, .O_RD_DATA, .O_RD_VALID, .O_RD_ERROR, .O_ACT_SLOT, .O_ACT_WR,
    .O_ACT_WDATA, .O_ACT_RD, .O_TGT_RDATA, .O_NV_STORE, .O_NV_DATA, .O_CFG_MISMATCH
  );
  slot_io_modules i_slot_io_modules
  (.i_clk(I_CLK_SYS), .i_slot(O_ACT_SLOT), .i_rd(O_ACT_RD), .o_rdata(I_ACT_RDATA));
  initial forever #50 I_CLK_SYS = ~I_CLK_SYS;
  ////////////////////////////////////////////////////////////////////////////
  task check(input string nm, input [511:0] e, g);
    begin
      compares = compares + 1;
      if (e !== g)
      begin
        fails = fails + 1;
        $display("FAIL %s exp %0h got %0h", nm, e, g);
      end
    end
  endtask
  task conclude;
    begin
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // Random byte below m
  function [7:0] rb(input integer m);
    rb = 8'($unsigned($random(seed)) % m);
  endfunction
  // Oldest note is matched to each answer; also the hang limit
  always @(posedge I_CLK_SYS)
  begin
    cyc = cyc + 1;
    if (cyc == 5000)
    begin
      fails = fails + 1;
      conclude;
    end
    #1;
    if (O_WR_DONE || O_WR_ERROR) check("wr", qw.pop_front(), {O_WR_DONE, O_WR_ERROR});
    if (O_RD_VALID || O_RD_ERROR)
      check("rd", qr.pop_front(), {O_RD_ERROR, O_RD_DATA & {8{~O_RD_ERROR}}});
    if (O_NV_STORE) check("nv", qs.size() ? qs.pop_front() : 512'h1, O_NV_DATA);
  end
  ////////////////////////////////////////////////////////////////////////////
  // Random record with ignore, virtual and slot codes and both slot bounds
  task mk;
    reg [7:0] c;
    for (j = 0; j < 64; j = j + 1)
    begin
      c = rb(6);
      rec[8*j +: 8] = c == 0 ? 8'h00 : c == 1 ? 8'hFF : c == 2 ? 8'h01 : c == 3 ? 8'h40
                      : rb(64) + 8'h01;
    end
  endtask
  // Whole write command; refused if index, count or a code is wrong
  // user sends n record bytes
  task wr_rec(input [7:0] idx, input integer n);
    reg ok;
    begin
      ok = idx == 8'h7F && n == 64;
      @(negedge I_CLK_SYS) {I_WR_START, I_WR_INDEX} = {1'b1, idx};
      for (j = 0; j < n; j = j + 1)
      begin
        @(negedge I_CLK_SYS) {I_WR_START, I_WR_VALID, I_WR_DATA} = {2'b01, rec[8*j +: 8]};
        if (rec[8*j +: 8] > 8'h40 && rec[8*j +: 8] < 8'hFF) ok = 0;
      end
      @(negedge I_CLK_SYS) {I_WR_VALID, I_WR_END} = 2'b01;
      qw.push_back({ok, !ok});
      if (ok && rec !== mdl) qs.push_back(rec);
      if (ok) mdl = rec;
      @(negedge I_CLK_SYS) I_WR_END = 0;
      repeat (2) @(negedge I_CLK_SYS);
    end
  endtask
  // Read request left standing for back to back use
  task rd(input [7:0] idx, input [5:0] a);
    begin
      @(negedge I_CLK_SYS) {I_RD_REQ, I_RD_INDEX, I_RD_ADDR} = {1'b1, idx, a};
      qr.push_back(idx == 8'h7F ? {1'b0, mdl[8*a +: 8]} : 9'h100);
    end
  endtask
  // Image access of target slot t, read with a random write at once
  task img(input [5:0] t);
    reg [7:0] c;
    reg       r;
    reg       w;
    begin
      c = on ? mdl[8*t +: 8] : t + 8'h01;
      r = c != 0 && c < 8'h41 && I_SLOT_PRESENT[c - 8'h01];
      w = rb(2) != 8'h00;
      @(negedge I_CLK_SYS) {I_TGT_SLOT, I_TGT_WR, I_TGT_WDATA} = {t, w, rb(256)};
      #10;
      check("act_wr", r && w, O_ACT_WR);
      check("act_rd", r, O_ACT_RD);
      check("tgt_rdata", r ? {2'b10, c[5:0] - 6'h01} : 8'h00, O_TGT_RDATA);
      if (r) check("act_slot", {c[5:0] - 6'h01}, O_ACT_SLOT);
    end
  endtask
  task chk_mm;
    reg [7:0] c;
    reg       e;
    begin
      e = !on && !(&I_SLOT_PRESENT);
      for (j = 0; j < 64; j = j + 1)
      begin
        c = mdl[8*j +: 8];
        if (on && c != 0 && c < 8'h41 && !I_SLOT_PRESENT[c - 8'h01]) e = 1;
      end
      check("mismatch", e, O_CFG_MISMATCH);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    mk;
    I_NV_DATA = rec;
    repeat (16) @(negedge I_CLK_SYS);
    I_RST_N = 1;
    I_NV_READY = 1;
    mdl = rec;
    repeat (4) @(negedge I_CLK_SYS);
    for (k = 0; k < 64; k = k + 1) rd(8'h7F, k);
    rd(8'h7E, 6'h00);
    @(negedge I_CLK_SYS) I_RD_REQ = 0;
    for (k = 0; k < 4; k = k + 1) img(k);
    chk_mm;
    $display("test restore and off done");
    // Switched on, synchronised over two edges
    @(negedge I_CLK_SYS) I_REMAP_ENABLE = 1;
    on = 1;
    repeat (3) @(negedge I_CLK_SYS);
    for (k = 0; k < 2; k = k + 1)
    begin
      mk;
      wr_rec(8'h7F, 64);
      wr_rec(8'h7F, 64);
      for (i = 0; i < 64; i = i + 1) img(i);
      chk_mm;
    end
    $display("test remap done");
    // Refused records leave the mapping untouched
    rec[87:80] = 8'h41;
    wr_rec(8'h7F, 64);
    rec[87:80] = 8'hFE;
    wr_rec(8'h7F, 64);
    rec[87:80] = 8'h00;
    wr_rec(8'h7E, 64);
    wr_rec(8'h7F, 63);
    for (k = 0; k < 64; k = k + 1) rd(8'h7F, k);
    @(negedge I_CLK_SYS) I_RD_REQ = 0;
    repeat (3) @(negedge I_CLK_SYS);
    // A frozen block leaves a standing read unanswered until released
    I_CE = 0;
    rd(8'h7F, 6'h05);
    repeat (3) @(negedge I_CLK_SYS);
    check("frozen", 0, O_RD_VALID); // Clock enable
    I_CE = 1;
    @(negedge I_CLK_SYS) I_RD_REQ = 0;
    repeat (3) @(negedge I_CLK_SYS);
    check("pending", 0, qw.size() + qr.size() + qs.size());
    $display("test refuse done");
    conclude;
  end
endmodule
